// [src/twd_pkg.sv]
package twd_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int INSTR_W = 16;
  localparam int PC_W = 21;
  localparam int DADDR_W = 12;
  localparam int DATA_W = 8;
  // ----------------------------------------
  // encodings
  // ----------------------------------------
  localparam logic [3:0] SECOND_PREFIX = 4'hF;
  localparam logic [7:0] OPC_CALL_HI = 8'hEC;
  localparam logic [6:0] OPC_CALL_MASK = 7'h76;
  localparam logic [3:0] OPC_MOVE_FF = 4'hC;
  localparam logic [7:0] OPC_JUMP = 8'hEF;
  localparam logic [9:0] OPC_LOAD_PTR = 10'h3B8;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  // ----------------------------------------
  // data map
  // ----------------------------------------
  localparam logic [DADDR_W-1:0] SPECIAL_LOW = 12'hF40;
  localparam logic [DADDR_W-1:0] SPECIAL_HIGH = 12'hFFF;
  localparam logic [DADDR_W-1:0] NOACC_LOW = 12'hEB0;
  localparam logic [DADDR_W-1:0] NOACC_HIGH = 12'hF5F;
  localparam logic [DADDR_W-1:0] ACC_HIGH_BASE = 12'hF00;
  localparam logic [DATA_W-1:0] UNIMPL_VALUE = 8'h00;
  typedef enum logic [1:0] {
    TWD_FIRST, TWD_SECOND
  } twd_phase_type;
endpackage

// [src/twd_impl_map.sv]
`timescale 1ns/1ps
// registered table of which special register addresses are implemented
module twd_impl_map #(
  parameter int ENTRIES = 192
) (
  // clock
  input wire logic ref_clk,
  // lookup
  input wire logic [7:0] index,
  output logic hit,
  // configuration
  input wire logic [ENTRIES-1:0] impl_mask
);
  always_ff @(posedge ref_clk) begin
    hit <= (index < 8'(ENTRIES)) ? impl_mask[index] : 1'b0;
  end
endmodule // twd_impl_map

// [src/twd_decoder.sv]
`timescale 1ns/1ps
// Behaviour
// - call, file move, jump and pointer load are the two-word instructions
// - second word has prefix 1111; low 12 bits are literal
// - second word after its first word yields its literal
// - second word alone executes as a no-operation, no state change
// - special register region spans F40h to FFFh
// - unimplemented special register locations read as zero
// - EB0h to F5Fh not reachable through access-bank addressing
// - absolute call or jump loads word address into PC bits 20:1
// - PC advances by two per sequential word
module twd_decoder
  import twd_pkg::*;
#(
  parameter int SPECIAL_ENTRIES = 192,
  parameter logic [SPECIAL_ENTRIES-1:0] SPECIAL_IMPL = '1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // fetch
  input wire logic instr_valid,
  input wire logic [twd_pkg::INSTR_W-1:0] instr_word,
  input wire logic skip_next,
  input wire logic redirect,
  input wire logic [twd_pkg::PC_W-1:0] redirect_pc,
  output logic [twd_pkg::PC_W-1:0] pc,
  // decode results
  output logic is_two_word,
  output logic literal_valid,
  output logic [twd_pkg::DADDR_W-1:0] literal,
  output logic orphan_nop,
  output logic pending_second,
  // data address decode
  input wire logic daddr_valid,
  input wire logic [twd_pkg::DADDR_W-1:0] daddr,
  input wire logic access_mode,
  input wire logic [twd_pkg::DATA_W-1:0] special_rdata_in,
  output logic in_special,
  output logic access_allowed,
  output logic [twd_pkg::DATA_W-1:0] special_rdata
);
  import twd_pkg::*;

  // ----------------------------------------
  // instruction classification
  // ----------------------------------------
  function automatic logic first_of_two(input logic [INSTR_W-1:0] w);
    logic call_hit;
    call_hit = (w[15:9] == OPC_CALL_MASK);
    return call_hit || (w[15:12] == OPC_MOVE_FF) ||
           (w[15:8] == OPC_JUMP) || (w[15:6] == OPC_LOAD_PTR);
  endfunction

  function automatic logic is_absolute(input logic [INSTR_W-1:0] w);
    return (w[15:9] == OPC_CALL_MASK) || (w[15:8] == OPC_JUMP);
  endfunction

  function automatic logic in_range(input logic [DADDR_W-1:0] a,
                                    input logic [DADDR_W-1:0] lo,
                                    input logic [DADDR_W-1:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  twd_phase_type phase_reg;
  logic [7:0] abs_low_reg;
  logic first_abs_reg;
  logic second_prefix;
  logic take_second;
  logic [PC_W-1:0] pc_next;

  assign second_prefix = instr_word[15:12] == SECOND_PREFIX;
  assign take_second = instr_valid && phase_reg == TWD_SECOND;

  // ----------------------------------------
  // pending second-word state
  // ----------------------------------------
  // a skip or redirect orphans any second word that follows
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase_reg <= TWD_FIRST;
    end else if (skip_next || redirect) begin
      phase_reg <= TWD_FIRST;
    end else if (instr_valid) begin
      case (phase_reg)
        TWD_FIRST: begin
          if (first_of_two(instr_word)) begin
            phase_reg <= TWD_SECOND;
          end
        end
        default: begin
          phase_reg <= TWD_FIRST;
        end
      endcase
    end
  end
  assign pending_second = phase_reg == TWD_SECOND;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      abs_low_reg <= 8'h00;
      first_abs_reg <= 1'b0;
    end else if (instr_valid && phase_reg == TWD_FIRST) begin
      abs_low_reg <= instr_word[7:0];
      first_abs_reg <= is_absolute(instr_word);
    end
  end

  // ----------------------------------------
  // decode outputs
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      is_two_word <= 1'b0;
      literal_valid <= 1'b0;
      literal <= 12'h000;
      orphan_nop <= 1'b0;
    end else begin
      is_two_word <= instr_valid && phase_reg == TWD_FIRST &&
                     first_of_two(instr_word);
      literal_valid <= take_second && second_prefix;
      if (take_second && second_prefix) begin
        literal <= instr_word[11:0];
      end
      // lone second word: flagged and PC steps by two; no other output moves
      orphan_nop <= instr_valid && phase_reg == TWD_FIRST &&
                    second_prefix;
    end
  end

  // ----------------------------------------
  // program counter
  // ----------------------------------------
  always_comb begin
    pc_next = pc;
    if (redirect) begin
      pc_next = {redirect_pc[PC_W-1:1], 1'b0};
    end else if (take_second && second_prefix && first_abs_reg) begin
      pc_next = {instr_word[11:0], abs_low_reg, 1'b0};
    end else if (instr_valid) begin
      pc_next = pc + PC_STEP;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pc <= PC_RESET;
    end else begin
      pc <= pc_next;
    end
  end

  // ----------------------------------------
  // special register region decode
  // ----------------------------------------
  logic impl_hit;
  logic [7:0] special_index;
  logic special_hit_reg;
  logic rd_pend_reg;
  logic [DATA_W-1:0] rdata_hold_reg;

  assign special_index = 8'(daddr - SPECIAL_LOW);

  twd_impl_map #(
    .ENTRIES(SPECIAL_ENTRIES)
  ) u_map (
    .ref_clk(ref_clk),
    .index(special_index),
    .hit(impl_hit),
    .impl_mask(SPECIAL_IMPL)
  );

  // access mode is refused EB0h..F5Fh; every other valid address is allowed
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      in_special <= 1'b0;
      access_allowed <= 1'b0;
      special_hit_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      rdata_hold_reg <= UNIMPL_VALUE;
    end else begin
      in_special <= daddr_valid &&
                    in_range(daddr, SPECIAL_LOW, SPECIAL_HIGH);
      access_allowed <= daddr_valid && !(access_mode &&
                        in_range(daddr, NOACC_LOW, NOACC_HIGH));
      special_hit_reg <= daddr_valid &&
                         in_range(daddr, SPECIAL_LOW, SPECIAL_HIGH);
      rd_pend_reg <= daddr_valid;
      rdata_hold_reg <= special_rdata_in;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      special_rdata <= UNIMPL_VALUE;
    end else if (rd_pend_reg) begin
      special_rdata <= (special_hit_reg && !impl_hit) ? UNIMPL_VALUE
                                                      : rdata_hold_reg;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  literal_pair_a: assert property (
    instr_valid && phase_reg == TWD_FIRST && first_of_two(instr_word) &&
    !skip_next && !redirect ##1 instr_valid && second_prefix
    |=> literal_valid && literal == $past(instr_word[11:0]))
    else $error("second word literal not taken");
  orphan_nop_a: assert property (
    orphan_nop |-> !literal_valid && !is_two_word && !pending_second &&
    $stable(literal))
    else $error("orphan word had an effect");
  skip_clear_a: assert property (
    skip_next || redirect |=> !pending_second)
    else $error("pending state survived skip");
  pc_step_a: assert property (
    instr_valid && !redirect && phase_reg == TWD_FIRST
    |=> pc == $past(pc) + PC_STEP)
    else $error("pc did not advance by two");
  pc_align_a: assert property (
    1'b1 |=> pc[0] == 1'b0)
    else $error("pc bit zero set");
  two_word_a: assert property (
    instr_valid && phase_reg == TWD_FIRST && instr_word[15:8] == OPC_JUMP
    |=> is_two_word)
    else $error("jump not two word");
  sfr_range_a: assert property (
    daddr_valid && daddr == SPECIAL_LOW |=> in_special)
    else $error("region start missed");
  no_access_a: assert property (
    daddr_valid && access_mode && daddr == NOACC_HIGH |=> !access_allowed)
    else $error("access bank reached hidden register");
  unimpl_zero_a: assert property (
    rd_pend_reg && special_hit_reg && !impl_hit
    |=> special_rdata == UNIMPL_VALUE)
    else $error("unimplemented read not zero");

  two_word_c: cover property (literal_valid);
  orphan_c: cover property (orphan_nop);
  abs_jump_c: cover property (literal_valid && $past(first_abs_reg));
  hidden_c: cover property (in_special && !access_allowed);
endmodule // twd_decoder

// [bench/twd_dmem.sv]
`timescale 1ns/1ps
// ----------------------------------------
// data storage stand-in
// ----------------------------------------
module twd_dmem
  import twd_pkg::*;
(
  // address
  input wire logic [twd_pkg::DADDR_W-1:0] daddr,
  // data
  output logic [twd_pkg::DATA_W-1:0] rdata
);
  // differs per address so a stale read shows
  assign rdata = daddr[7:0] ^ {daddr[11:8], 4'hA};
endmodule // twd_dmem

// [bench/tb_two_word_decode_sfr_region.sv]
`timescale 1ns/1ps
module tb_two_word_decode_sfr_region;
  import twd_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam logic [15:0] OPS [5] = '{16'hEF03, 16'hEC05, 16'hC123,
    16'hEE01, 16'h0F55};
  localparam logic [11:0] CRN [8] = '{12'hF40, 12'hF3F, 12'hFFF,
    12'hEB0, 12'hEAF, 12'hF5F, 12'hF60, 12'hF41};
  logic ref_clk, reset, instr_valid, skip_next, redirect, tw, pd;
  logic [15:0] instr_word;
  logic [20:0] redirect_pc, pc, pc_exp;
  logic is_two_word, literal_valid, orphan_nop, pending_second;
  logic [11:0] literal, daddr, lit, last_lit, a;
  logic daddr_valid, access_mode, in_special, access_allowed, m;
  logic [7:0] rdata_in, special_rdata;
  int bad_count, n_checks, cyc;
  twd_decoder #(.SPECIAL_IMPL({{191{1'b1}}, 1'b0})) dut (.ref_clk(ref_clk),
    .reset(reset), .instr_valid(instr_valid), .instr_word(instr_word),
    .skip_next(skip_next), .redirect(redirect), .redirect_pc(redirect_pc),
    .pc(pc), .is_two_word(is_two_word), .literal_valid(literal_valid),
    .literal(literal), .orphan_nop(orphan_nop),
    .pending_second(pending_second), .daddr_valid(daddr_valid),
    .daddr(daddr), .access_mode(access_mode),
    .special_rdata_in(rdata_in), .in_special(in_special),
    .access_allowed(access_allowed), .special_rdata(special_rdata));
  twd_dmem mem (.daddr(daddr), .rdata(rdata_in));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  // first slot is left unimplemented at the instance above
  function automatic logic [7:0] exp_rd(input logic [11:0] ad);
    return (ad == 12'hF40) ? 8'h00 : ad[7:0] ^ {ad[11:8], 4'hA};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task pair(input logic [15:0] w1, input logic [15:0] w2, input logic sk,
            input logic rd, input logic [20:0] rpc);
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr_word <= w1;
    skip_next <= sk;
    redirect <= rd;
    redirect_pc <= rpc;
    @(posedge ref_clk);
    instr_word <= w2;
    skip_next <= 1'b0;
    redirect <= 1'b0;
    #1 tw = is_two_word;
    pd = pending_second;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  task dchk(input logic [11:0] ad, input logic md);
    @(posedge ref_clk);
    daddr_valid <= 1'b1;
    daddr <= ad;
    access_mode <= md;
    @(posedge ref_clk);
    daddr_valid <= 1'b0;
    #1 chk(in_special, ad >= 12'hF40);
    chk(access_allowed, !(md && ad >= 12'hEB0 && ad <= 12'hF5F));
    @(posedge ref_clk);
    #1;
    if (ad >= 12'hF40)
      chk(special_rdata, exp_rd(ad));
  endtask
  task conclude;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    reset = 1'b1;
    {instr_valid, skip_next, redirect, daddr_valid, access_mode} = 5'h00;
    instr_word = 16'h0000;
    redirect_pc = 21'h000000;
    daddr = 12'h000;
    pc_exp = 21'h000000;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    void'($urandom(32'h05F4));
    for (int i = 0; i < 5; i++) begin
      lit = 12'($urandom);
      pair(OPS[i], {(i == 4) ? 4'h2 : 4'hF, lit}, 1'b0, 1'b0, 21'h0);
      chk(tw, i < 4);
      chk(pd, i < 4);
      chk(orphan_nop, 1'b0);
      chk(literal_valid, i < 4);
      if (i < 4) last_lit = lit;
      chk(literal, last_lit);
      pc_exp = (i < 2) ? {lit, OPS[i][7:0], 1'b0} : pc_exp + 21'h4;
      chk(pc, pc_exp);
    end
    $display("two-word pairs done");
    for (int k = 0; k < 2; k++) begin
      lit = 12'($urandom);
      pair(16'hC123, {4'hF, lit}, k == 0, k == 1, 21'h000100);
      chk(orphan_nop, 1'b1);
      chk(literal_valid, 1'b0);
      chk(literal, last_lit);
      chk(pending_second, 1'b0);
      chk(pd, 1'b0);
      pc_exp = (k == 0) ? pc_exp + 21'h4 : 21'h000102;
      chk(pc, pc_exp);
    end
    $display("orphan words done");
    for (int i = 0; i < 48; i++) begin
      a = (i < 8) ? CRN[i] : 12'($urandom);
      m = (i < 8) ? 1'b1 : 1'($urandom);
      dchk(a, m);
    end
    $display("data decode done");
    conclude();
  end
endmodule // tb_two_word_decode_sfr_region
